// file: rtl/slt_core.sv
// Sequencer for call, return, loop, trap and interrupt-return instructions.
// Assumes the decoder supplies the opcode, the evaluated destination address
// and the PC already advanced past all instruction words; memory answers by ack.
`timescale 1ns/10ps
module slt_core
    import slt_pkg::*;
(
    input  wire logic        mclk_i,
    input  wire logic        srst_i,
    input  wire logic        start_i,
    input  wire logic [15:0] instr_i,
    input  wire logic [15:0] dst_addr_i,
    input  wire logic [15:0] next_pc_i,
    input  wire logic [15:0] reg_rdata_i,
    input  wire logic [15:0] mem_rdata_i,
    input  wire logic        mem_ack_i,
    output logic             busy_o,
    output logic             done_o,
    output logic             illegal_o,
    output logic [2:0]       reg_sel_o,
    output logic             reg_we_o,
    output logic [2:0]       reg_waddr_o,
    output logic [15:0]      reg_wdata_o,
    output logic             mem_req_o,
    output logic             mem_we_o,
    output logic [15:0]      mem_addr_o,
    output logic [15:0]      mem_wdata_o,
    output logic [15:0]      pc_o,
    output logic [15:0]      sp_o,
    output logic [15:0]      psw_o
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] slt_dec2(input logic [15:0] v);
        slt_dec2 = v - SLT_WORD_STEP;
    endfunction

    function automatic logic [15:0] slt_inc2(input logic [15:0] v);
        slt_inc2 = v + SLT_WORD_STEP;
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    slt_state_e  state_reg,   state_next;
    slt_op_e     op_reg,      op_next;
    logic [15:0] tmp_reg,     tmp_next;
    logic [15:0] hold_reg,    hold_next;
    logic [2:0]  rsel_reg,    rsel_next;
    logic [15:0] pc_reg,      pc_next;
    logic [15:0] sp_reg,      sp_next;
    logic [15:0] psw_reg,     psw_next;
    logic        busy_reg,    busy_next;
    logic        done_reg,    done_next;
    logic        ill_reg,     ill_next;
    logic        rwe_reg,     rwe_next;
    logic [2:0]  rwa_reg,     rwa_next;
    logic [15:0] rwd_reg,     rwd_next;
    logic        mreq_reg,    mreq_next;
    logic        mwe_reg,     mwe_next;
    logic [15:0] maddr_reg,   maddr_next;
    logic [15:0] mwd_reg,     mwd_next;

    logic [15:0] loop_cnt;
    logic [15:0] loop_ofs;

    assign loop_cnt = reg_rdata_i - 16'h0001;
    assign loop_ofs = {9'h000, instr_i[5:0], 1'b0};

    always_comb begin
        state_next = state_reg;
        op_next    = op_reg;
        tmp_next   = tmp_reg;
        hold_next  = hold_reg;
        rsel_next  = rsel_reg;
        pc_next    = pc_reg;
        sp_next    = sp_reg;
        psw_next   = psw_reg;
        busy_next  = busy_reg;
        done_next  = 1'b0;
        ill_next   = 1'b0;
        rwe_next   = 1'b0;
        rwa_next   = rwa_reg;
        rwd_next   = rwd_reg;
        mreq_next  = mreq_reg;
        mwe_next   = mwe_reg;
        maddr_next = maddr_reg;
        mwd_next   = mwd_reg;
        unique case (state_reg)
            SLT_IDLE: begin
                if (start_i) begin
                    pc_next = next_pc_i;
                    if ((instr_i & SLT_OPC_CALL_MASK) == SLT_OPC_CALL) begin
                        rsel_next = instr_i[8:6];
                        tmp_next  = dst_addr_i;
                        busy_next = 1'b1;
                        if (instr_i[8:6] == SLT_REG_PC && instr_i[5:0] == {3'h3, SLT_REG_SP}) begin
                            op_next    = SLT_OP_SWAP;
                            sp_next    = slt_inc2(sp_reg);
                            tmp_next   = next_pc_i;
                            state_next = SLT_SWAPR;
                        end else begin
                            op_next    = SLT_OP_CALL;
                            sp_next    = slt_dec2(sp_reg);
                            mreq_next  = 1'b1;
                            mwe_next   = 1'b1;
                            maddr_next = slt_dec2(sp_reg);
                            mwd_next   = (instr_i[8:6] == SLT_REG_PC) ? next_pc_i : reg_rdata_i;
                            state_next = SLT_PUSH1;
                        end
                    end else if ((instr_i & SLT_OPC_RET_MASK) == SLT_OPC_RET) begin
                        op_next    = SLT_OP_RET;
                        rsel_next  = instr_i[2:0];
                        pc_next    = reg_rdata_i;
                        busy_next  = 1'b1;
                        mreq_next  = 1'b1;
                        mwe_next   = 1'b0;
                        maddr_next = sp_reg;
                        state_next = SLT_POP1;
                    end else if ((instr_i & SLT_OPC_LOOP_MASK) == SLT_OPC_LOOP) begin
                        rwe_next  = 1'b1;
                        rwa_next  = instr_i[8:6];
                        rwd_next  = loop_cnt;
                        if (loop_cnt != 16'h0000) begin
                            pc_next = next_pc_i - loop_ofs;
                        end
                        done_next = 1'b1;
                    end else if (instr_i == SLT_OPC_IRET || instr_i == SLT_OPC_TRET) begin
                        op_next    = SLT_OP_IRET;
                        busy_next  = 1'b1;
                        mreq_next  = 1'b1;
                        mwe_next   = 1'b0;
                        maddr_next = sp_reg;
                        state_next = SLT_POP1;
                    end else if ((instr_i & SLT_OPC_EMUL_MASK) == SLT_OPC_EMUL ||
                                 (instr_i & SLT_OPC_TRAPI_MSK) == SLT_OPC_TRAPI ||
                                 instr_i == SLT_OPC_BPT || instr_i == SLT_OPC_IOT) begin
                        op_next = SLT_OP_TRAP;
                        if ((instr_i & SLT_OPC_EMUL_MASK) == SLT_OPC_EMUL) begin
                            tmp_next = SLT_VEC_EMUL;
                        end else if ((instr_i & SLT_OPC_TRAPI_MSK) == SLT_OPC_TRAPI) begin
                            tmp_next = SLT_VEC_TRAPI;
                        end else if (instr_i == SLT_OPC_BPT) begin
                            tmp_next = SLT_VEC_BPT;
                        end else begin
                            tmp_next = SLT_VEC_IOT;
                        end
                        busy_next  = 1'b1;
                        sp_next    = slt_dec2(sp_reg);
                        mreq_next  = 1'b1;
                        mwe_next   = 1'b1;
                        maddr_next = slt_dec2(sp_reg);
                        mwd_next   = psw_reg;
                        state_next = SLT_PUSH1;
                    end else begin
                        ill_next  = 1'b1;
                        done_next = 1'b1;
                    end
                end
            end
            SLT_SWAPR: begin
                mreq_next  = 1'b1;
                mwe_next   = 1'b0;
                maddr_next = slt_dec2(sp_reg);
                state_next = SLT_POP1;
            end
            SLT_PUSH1: begin
                if (mem_ack_i) begin
                    mreq_next = 1'b0;
                    if (op_reg == SLT_OP_CALL) begin
                        if (rsel_reg != SLT_REG_PC) begin
                            rwe_next = 1'b1;
                            rwa_next = rsel_reg;
                            rwd_next = pc_reg;
                        end
                        pc_next    = tmp_reg;
                        state_next = SLT_DONE;
                    end else begin
                        sp_next    = slt_dec2(sp_reg);
                        mreq_next  = 1'b1;
                        maddr_next = slt_dec2(sp_reg);
                        mwd_next   = pc_reg;
                        state_next = SLT_PUSH2;
                    end
                end
            end
            SLT_PUSH2: begin
                if (mem_ack_i) begin
                    mwe_next   = 1'b0;
                    if (op_reg == SLT_OP_SWAP) begin
                        mreq_next  = 1'b0;
                        pc_next    = hold_reg;
                        state_next = SLT_DONE;
                    end else begin
                        maddr_next = tmp_reg;
                        state_next = SLT_VEC1;
                    end
                end
            end
            SLT_VEC1: begin
                if (mem_ack_i) begin
                    pc_next    = mem_rdata_i;
                    maddr_next = slt_inc2(tmp_reg);
                    state_next = SLT_VEC2;
                end
            end
            SLT_VEC2: begin
                if (mem_ack_i) begin
                    psw_next   = mem_rdata_i;
                    mreq_next  = 1'b0;
                    state_next = SLT_DONE;
                end
            end
            SLT_POP1: begin
                if (mem_ack_i) begin
                    if (op_reg == SLT_OP_SWAP) begin
                        hold_next  = mem_rdata_i;
                        sp_next    = slt_dec2(sp_reg);
                        mwe_next   = 1'b1;
                        mwd_next   = tmp_reg;
                        maddr_next = slt_dec2(sp_reg);
                        state_next = SLT_PUSH2;
                    end else if (op_reg == SLT_OP_RET) begin
                        mreq_next  = 1'b0;
                        sp_next    = slt_inc2(sp_reg);
                        if (rsel_reg != SLT_REG_PC) begin
                            rwe_next = 1'b1;
                            rwa_next = rsel_reg;
                            rwd_next = mem_rdata_i;
                        end else begin
                            pc_next = mem_rdata_i;
                        end
                        state_next = SLT_DONE;
                    end else begin
                        pc_next    = mem_rdata_i;
                        sp_next    = slt_inc2(sp_reg);
                        maddr_next = slt_inc2(sp_reg);
                        state_next = SLT_POP2;
                    end
                end
            end
            SLT_POP2: begin
                if (mem_ack_i) begin
                    psw_next   = mem_rdata_i;
                    sp_next    = slt_inc2(sp_reg);
                    mreq_next  = 1'b0;
                    state_next = SLT_DONE;
                end
            end
            SLT_DONE: begin
                hold_next  = 16'h0000;
                busy_next  = 1'b0;
                done_next  = 1'b1;
                op_next    = SLT_OP_NONE;
                state_next = SLT_IDLE;
            end
            default: begin
                state_next = SLT_IDLE;
                busy_next  = 1'b0;
                mreq_next  = 1'b0;
            end
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            state_reg <= SLT_IDLE;
            op_reg    <= SLT_OP_NONE;
            tmp_reg   <= 16'h0000;
            hold_reg  <= 16'h0000;
            rsel_reg  <= 3'h0;
            pc_reg    <= SLT_PC_RST;
            sp_reg    <= SLT_SP_RST;
            psw_reg   <= SLT_PSW_RST;
            busy_reg  <= 1'b0;
            done_reg  <= 1'b0;
            ill_reg   <= 1'b0;
            rwe_reg   <= 1'b0;
            rwa_reg   <= 3'h0;
            rwd_reg   <= 16'h0000;
            mreq_reg  <= 1'b0;
            mwe_reg   <= 1'b0;
            maddr_reg <= 16'h0000;
            mwd_reg   <= 16'h0000;
        end else begin
            state_reg <= state_next;
            op_reg    <= op_next;
            tmp_reg   <= tmp_next;
            hold_reg  <= hold_next;
            rsel_reg  <= rsel_next;
            pc_reg    <= pc_next;
            sp_reg    <= sp_next;
            psw_reg   <= psw_next;
            busy_reg  <= busy_next;
            done_reg  <= done_next;
            ill_reg   <= ill_next;
            rwe_reg   <= rwe_next;
            rwa_reg   <= rwa_next;
            rwd_reg   <= rwd_next;
            mreq_reg  <= mreq_next;
            mwe_reg   <= mwe_next;
            maddr_reg <= maddr_next;
            mwd_reg   <= mwd_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign busy_o      = busy_reg;
    assign done_o      = done_reg;
    assign illegal_o   = ill_reg;
    assign reg_sel_o   = rsel_reg;
    assign reg_we_o    = rwe_reg;
    assign reg_waddr_o = rwa_reg;
    assign reg_wdata_o = rwd_reg;
    assign mem_req_o   = mreq_reg;
    assign mem_we_o    = mwe_reg;
    assign mem_addr_o  = maddr_reg;
    assign mem_wdata_o = mwd_reg;
    assign pc_o        = pc_reg;
    assign sp_o        = sp_reg;
    assign psw_o       = psw_reg;

endmodule // slt_core

// file: rtl/slt_pkg.sv
// Constants for the subroutine, loop and trap sequencer.
// Assumes a word-wide memory port with a one-cycle handshake, single clock.
//
// Function
// - Call pushes linkage register, then reloads it
// - Call target held in temporary before push
// - Linkage gets address after whole call
// - Call via PC alters only SP, PC
// - Call PC,@(SP)+ swaps stack top with PC
// - Return: register to PC, pop register
// - Loop decrements, branches back when nonzero
// - Loop offset unsigned six bits, backward only
// - Loop leaves condition codes unchanged
// - Trap pushes status, PC; loads vector pair
// - Interrupt returns pop PC then status
// - Trap vectors at fixed addresses
package slt_pkg;
    localparam logic [15:0] SLT_OPC_CALL_MASK = 16'hfe00;
    localparam logic [15:0] SLT_OPC_CALL      = 16'h0800;
    localparam logic [15:0] SLT_OPC_RET_MASK  = 16'hfff8;
    localparam logic [15:0] SLT_OPC_RET       = 16'h0080;
    localparam logic [15:0] SLT_OPC_LOOP_MASK = 16'hfe00;
    localparam logic [15:0] SLT_OPC_LOOP      = 16'h7e00;
    localparam logic [15:0] SLT_OPC_IRET      = 16'h0002;
    localparam logic [15:0] SLT_OPC_TRET      = 16'h0006;
    localparam logic [15:0] SLT_OPC_EMUL_MASK = 16'hff00;
    localparam logic [15:0] SLT_OPC_EMUL      = 16'h8800;
    localparam logic [15:0] SLT_OPC_TRAPI_MSK = 16'hff00;
    localparam logic [15:0] SLT_OPC_TRAPI     = 16'h8900;
    localparam logic [15:0] SLT_OPC_BPT       = 16'h0003;
    localparam logic [15:0] SLT_OPC_IOT       = 16'h0004;
    localparam logic [15:0] SLT_VEC_EMUL      = 16'h0018;
    localparam logic [15:0] SLT_VEC_TRAPI     = 16'h001c;
    localparam logic [15:0] SLT_VEC_BPT       = 16'h000c;
    localparam logic [15:0] SLT_VEC_IOT       = 16'h0010;
    localparam logic [15:0] SLT_WORD_STEP     = 16'h0002;
    localparam logic [15:0] SLT_PC_RST        = 16'h0000;
    localparam logic [15:0] SLT_SP_RST        = 16'h0000;
    localparam logic [15:0] SLT_PSW_RST       = 16'h0000;
    localparam logic [2:0]  SLT_REG_SP        = 3'h6;
    localparam logic [2:0]  SLT_REG_PC        = 3'h7;
    localparam int          SLT_CC_LSB        = 0;
    localparam int          SLT_CC_MSB        = 3;
    typedef enum logic [3:0] {
        SLT_IDLE  = 4'h0,
        SLT_PUSH1 = 4'h1,
        SLT_PUSH2 = 4'h3,
        SLT_POP1  = 4'h2,
        SLT_POP2  = 4'h6,
        SLT_VEC1  = 4'h7,
        SLT_VEC2  = 4'h5,
        SLT_DONE  = 4'h4,
        SLT_SWAPR = 4'hc
    } slt_state_e;
    typedef enum logic [2:0] {
        SLT_OP_NONE = 3'h0,
        SLT_OP_CALL = 3'h1,
        SLT_OP_SWAP = 3'h2,
        SLT_OP_RET  = 3'h3,
        SLT_OP_IRET = 3'h4,
        SLT_OP_TRAP = 3'h5
    } slt_op_e;
endpackage

// file: sim/slt_core_properties.sv
// Concurrent checks on the ports of the call, return, loop and trap sequencer.
// Assumes a single clock and a synchronous reset; bound to slt_core from the bench.
`timescale 1ns/10ps
module slt_core_properties
    import slt_pkg::*;
(
    input wire logic        mclk_i,
    input wire logic        srst_i,
    input wire logic        start_i,
    input wire logic [15:0] instr_i,
    input wire logic [15:0] dst_addr_i,
    input wire logic [15:0] next_pc_i,
    input wire logic [15:0] reg_rdata_i,
    input wire logic        mem_ack_i,
    input wire logic        busy_o,
    input wire logic        done_o,
    input wire logic        reg_we_o,
    input wire logic [2:0]  reg_waddr_o,
    input wire logic [15:0] reg_wdata_o,
    input wire logic        mem_req_o,
    input wire logic        mem_we_o,
    input wire logic [15:0] mem_addr_o,
    input wire logic [15:0] mem_wdata_o,
    input wire logic [15:0] pc_o,
    input wire logic [15:0] sp_o,
    input wire logic [15:0] psw_o
);
    // ----------------------------------------
    // Capture of the accepted request
    // ----------------------------------------
    logic [15:0] c_ins, c_rd, c_npc, c_dst, c_sp, c_vec;
    logic        c_loop, c_call, c_swap, c_ret, c_iret, s_loop;
    always_ff @(posedge mclk_i) begin
        if (start_i && !busy_o) begin
            c_ins <= instr_i;
            c_rd  <= reg_rdata_i;
            c_npc <= next_pc_i;
            c_dst <= dst_addr_i;
            c_sp  <= sp_o;
        end
    end
    assign s_loop = start_i && !busy_o && (instr_i & SLT_OPC_LOOP_MASK) == SLT_OPC_LOOP;
    assign c_loop = (c_ins & SLT_OPC_LOOP_MASK) == SLT_OPC_LOOP;
    assign c_call = (c_ins & SLT_OPC_CALL_MASK) == SLT_OPC_CALL;
    assign c_swap = c_call && c_ins[8:0] == 9'h1de;
    assign c_ret  = (c_ins & SLT_OPC_RET_MASK) == SLT_OPC_RET;
    assign c_iret = c_ins == SLT_OPC_IRET || c_ins == SLT_OPC_TRET;
    assign c_vec  = (c_ins & SLT_OPC_EMUL_MASK) == SLT_OPC_EMUL ? SLT_VEC_EMUL :
                    (c_ins & SLT_OPC_TRAPI_MSK) == SLT_OPC_TRAPI ? SLT_VEC_TRAPI :
                    c_ins == SLT_OPC_BPT ? SLT_VEC_BPT : c_ins == SLT_OPC_IOT ? SLT_VEC_IOT : 16'h0000;
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (srst_i);
    a_loop_done_fast: assert property (s_loop |-> ##[1:2] done_o)
        else $error("loop did not finish at once");
    a_loop_cc_kept: assert property (s_loop |=> $stable(psw_o) [*2])
        else $error("loop changed the status word");
    a_loop_new_count: assert property (reg_we_o && c_loop |-> reg_wdata_o == c_rd - 16'h0001 && reg_waddr_o == c_ins[8:6])
        else $error("loop count written wrong");
    a_loop_back_only: assert property (done_o && c_loop |-> pc_o == (c_rd == 16'h0001 ? c_npc : c_npc - {c_ins[5:0], 1'b0}))
        else $error("loop target wrong");
    a_call_link_val: assert property (reg_we_o && c_call |-> reg_wdata_o == c_npc && reg_waddr_o == c_ins[8:6])
        else $error("call linkage value wrong");
    a_call_pc_only: assert property (c_call && c_ins[8:6] == SLT_REG_PC |-> !reg_we_o)
        else $error("call through pc wrote a register");
    a_call_push_old: assert property (mem_req_o && mem_we_o && c_call && !c_swap |-> mem_wdata_o == c_rd)
        else $error("call pushed wrong word");
    a_call_pc_dst: assert property (done_o && c_call && !c_swap |-> pc_o == c_dst)
        else $error("call target wrong");
    a_push_at_sp: assert property (mem_req_o && mem_we_o |-> mem_addr_o == sp_o)
        else $error("push not at stack pointer");
    a_trap_vec_fixed: assert property (mem_req_o && !mem_we_o && c_vec != 16'h0000 |-> mem_addr_o == c_vec || mem_addr_o == c_vec + 16'h0002)
        else $error("trap vector read elsewhere");
    a_trap_sp_down: assert property (done_o && c_vec != 16'h0000 |-> sp_o == c_sp - 16'h0004)
        else $error("trap stack depth wrong");
    a_ret_pc_load: assert property (done_o && c_ret && c_ins[2:0] != SLT_REG_PC |-> pc_o == c_rd)
        else $error("return pc wrong");
    a_iret_sp_up: assert property (done_o && c_iret |-> sp_o == c_sp + 16'h0004)
        else $error("interrupt return stack wrong");
endmodule // slt_core_properties

// file: sim/test_subroutine_loop_trap_control.sv
// Self-checking bench for slt_core: random traps, returns, loops and calls.
// Assumes the bench plays decoder and memory; inputs move on the falling edge.
`timescale 1ns/10ps
module test_subroutine_loop_trap_control
    import slt_pkg::*;
;
    // ----------------------------------------
    // Stimulus and design
    // ----------------------------------------
    logic        mclk_i = 1'b0, srst_i = 1'b1, start_i = 1'b0, mem_ack_i = 1'b0;
    logic [15:0] instr_i = 16'h0000, dst_addr_i = 16'h0000, next_pc_i = 16'h0000;
    logic [15:0] reg_rdata_i = 16'h0000, mem_rdata_i = 16'h0000;
    wire logic        busy_o, done_o, illegal_o, reg_we_o, mem_req_o, mem_we_o;
    wire logic [2:0]  reg_sel_o, reg_waddr_o;
    wire logic [15:0] reg_wdata_o, mem_addr_o, mem_wdata_o, pc_o, sp_o, psw_o;
    int          mismatches = 0, cmp_count = 0, wr_n = 0, w0 = 0;
    logic [2:0]  wr_a;
    logic [15:0] wr_d;
    always #50 mclk_i = ~mclk_i;
    slt_core DUT (.mclk_i(mclk_i), .srst_i(srst_i), .start_i(start_i), .instr_i(instr_i),
        .dst_addr_i(dst_addr_i), .next_pc_i(next_pc_i), .reg_rdata_i(reg_rdata_i),
        .mem_rdata_i(mem_rdata_i), .mem_ack_i(mem_ack_i), .busy_o(busy_o), .done_o(done_o),
        .illegal_o(illegal_o), .reg_sel_o(reg_sel_o), .reg_we_o(reg_we_o), .reg_waddr_o(reg_waddr_o),
        .reg_wdata_o(reg_wdata_o), .mem_req_o(mem_req_o), .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o),
        .mem_wdata_o(mem_wdata_o), .pc_o(pc_o), .sp_o(sp_o), .psw_o(psw_o));
    always @(posedge mclk_i) begin
        if (reg_we_o === 1'b1) begin
            wr_n++;
            wr_a = reg_waddr_o;
            wr_d = reg_wdata_o;
        end
    end
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task complete_run;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task issue(input logic [15:0] ins, input logic [15:0] dst, input logic [15:0] npc, input logic [15:0] rd);
        w0 = wr_n;
        start_i = 1'b1;
        instr_i = ins;
        dst_addr_i = dst;
        next_pc_i = npc;
        reg_rdata_i = rd;
        @(negedge mclk_i);
        start_i = 1'b0;
        dst_addr_i = ~dst;
        reg_rdata_i = ~rd;
    endtask
    task wait_for(input logic sig_sel);
        int n;
        n = 0;
        while ((sig_sel ? mem_req_o : done_o) !== 1'b1 && n < 40) begin
            @(negedge mclk_i);
            n++;
        end
        if (n == 40) begin
            mismatches++;
            complete_run();
        end
    endtask
    task mem(input logic we, input logic [15:0] a, input logic [15:0] wd, input logic [15:0] rd);
        wait_for(1'b1);
        chk(16'(busy_o), 16'h0001);
        chk(16'(mem_we_o), 16'(we));
        chk(mem_addr_o, a);
        if (we)
            chk(mem_wdata_o, wd);
        mem_ack_i = 1'b1;
        mem_rdata_i = rd;
        @(negedge mclk_i);
        mem_ack_i = 1'b0;
        mem_rdata_i = ~rd;
    endtask
    task fin(input logic [15:0] pc, input logic [15:0] sp, input logic [15:0] psw, input logic ill);
        wait_for(1'b0);
        chk(pc_o, pc);
        chk(sp_o, sp);
        chk(psw_o, psw);
        chk(16'(illegal_o), 16'(ill));
        @(negedge mclk_i);
        $display("test finished at %0t", $time);
    endtask
    task regchk(input int n, input logic [2:0] a, input logic [15:0] d);
        chk(16'(wr_n - w0), 16'(n));
        if (n > 0) begin
            chk(16'(wr_a), 16'(a));
            chk(wr_d, d);
        end
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        int          i;
        logic [2:0]  r;
        logic [5:0]  ofs;
        logic [15:0] v, np, d, top, vec, sp, pc, psw;
        v = 16'($urandom(95195));
        sp = 16'h0000;
        pc = 16'h0000;
        psw = 16'h0000;
        repeat (12) @(negedge mclk_i);
        srst_i = 1'b0;
        chk(pc_o, 16'h0000);
        chk(sp_o, 16'h0000);
        chk(16'(busy_o), 16'h0000);
        for (i = 0; i < 4; i++) begin
            top = i == 0 ? SLT_OPC_EMUL | 16'($urandom % 256) : i == 1 ? SLT_OPC_TRAPI | 16'($urandom % 256) :
                  i == 2 ? SLT_OPC_BPT : SLT_OPC_IOT;
            vec = i == 0 ? SLT_VEC_EMUL : i == 1 ? SLT_VEC_TRAPI : i == 2 ? SLT_VEC_BPT : SLT_VEC_IOT;
            np = 16'($urandom);
            d = 16'($urandom);
            v = 16'($urandom);
            issue(top, 16'h0000, np, 16'h0000);
            mem(1'b1, sp - 16'h0002, psw, 16'h0000);
            mem(1'b1, sp - 16'h0004, np, 16'h0000);
            mem(1'b0, vec, 16'h0000, d);
            mem(1'b0, vec + 16'h0002, 16'h0000, v);
            sp = sp - 16'h0004;
            pc = d;
            psw = v;
            fin(pc, sp, psw, 1'b0);
            regchk(0, 3'h0, 16'h0000);
        end
        for (i = 0; i < 2; i++) begin
            d = 16'($urandom);
            v = 16'($urandom);
            issue(i == 0 ? SLT_OPC_IRET : SLT_OPC_TRET, 16'h0000, 16'($urandom), 16'h0000);
            mem(1'b0, sp, 16'h0000, d);
            mem(1'b0, sp + 16'h0002, 16'h0000, v);
            sp = sp + 16'h0004;
            pc = d;
            psw = v;
            fin(pc, sp, psw, 1'b0);
        end
        for (i = 0; i < 12; i++) begin
            r = 3'($urandom % 6);
            v = i == 0 ? 16'h0001 : i == 1 ? 16'h0000 : 16'($urandom);
            ofs = i < 2 ? 6'h3f : i == 2 ? 6'h00 : 6'($urandom);
            np = 16'($urandom);
            issue(SLT_OPC_LOOP | {r, ofs}, 16'h0000, np, v);
            pc = (v - 16'h0001 != 16'h0000) ? np - {ofs, 1'b0} : np;
            fin(pc, sp, psw, 1'b0);
            regchk(1, r, v - 16'h0001);
        end
        for (i = 0; i < 4; i++) begin
            r = i == 0 ? SLT_REG_PC : 3'($urandom % 6);
            np = 16'($urandom);
            d = 16'($urandom);
            v = r == SLT_REG_PC ? np : 16'($urandom);
            issue(SLT_OPC_CALL | {r, 6'h37}, d, np, v);
            mem(1'b1, sp - 16'h0002, v, 16'h0000);
            sp = sp - 16'h0002;
            pc = d;
            fin(pc, sp, psw, 1'b0);
            chk(16'(reg_sel_o), 16'(r));
            regchk(r == SLT_REG_PC ? 0 : 1, r, np);
        end
        np = 16'($urandom);
        d = 16'($urandom);
        issue(SLT_OPC_CALL | 16'h01de, d, np, np);
        mem(1'b0, sp, 16'h0000, d);
        mem(1'b1, sp, np, 16'h0000);
        pc = d;
        fin(pc, sp, psw, 1'b0);
        regchk(0, 3'h0, 16'h0000);
        for (i = 0; i < 3; i++) begin
            r = i == 0 ? SLT_REG_PC : 3'($urandom % 6);
            v = 16'($urandom);
            d = 16'($urandom);
            issue(SLT_OPC_RET | 16'(r), 16'h0000, 16'($urandom), v);
            mem(1'b0, sp, 16'h0000, d);
            sp = sp + 16'h0002;
            pc = r == SLT_REG_PC ? d : v;
            fin(pc, sp, psw, 1'b0);
            chk(16'(reg_sel_o), 16'(r));
            if (r != SLT_REG_PC)
                regchk(1, r, d);
        end
        np = 16'($urandom);
        issue(16'h00a0, 16'h0000, np, 16'h0000);
        fin(np, sp, psw, 1'b1);
        complete_run();
    end
endmodule // test_subroutine_loop_trap_control

bind slt_core slt_core_properties u_props (.mclk_i(mclk_i), .srst_i(srst_i), .start_i(start_i),
    .instr_i(instr_i), .dst_addr_i(dst_addr_i), .next_pc_i(next_pc_i), .reg_rdata_i(reg_rdata_i),
    .mem_ack_i(mem_ack_i), .busy_o(busy_o), .done_o(done_o), .reg_we_o(reg_we_o),
    .reg_waddr_o(reg_waddr_o), .reg_wdata_o(reg_wdata_o), .mem_req_o(mem_req_o), .mem_we_o(mem_we_o),
    .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .pc_o(pc_o), .sp_o(sp_o), .psw_o(psw_o));
